// [common/sehp_defines.vh]
// constants for the serial eeprom command, protect and hold logic
`ifndef SEHP_DEFINES_VH
`define SEHP_DEFINES_VH
`define SEHP_OP_WRITE_ENABLE_COMMAND      8'h06
`define SEHP_OP_WRITE_DISABLE_COMMAND      8'h04
`define SEHP_OP_RDST      8'h05
`define SEHP_OP_WRST      8'h01
`define SEHP_OP_READ      8'h03
`define SEHP_OP_WRITE     8'h02
`define SEHP_ST_BUSY      0
`define SEHP_ST_WEL       1
`define SEHP_ST_BPL       2
`define SEHP_ST_BPH       3
`define SEHP_ST_PPEN      7
`define SEHP_ST_WR_MASK   8'h8C
`define SEHP_ST_RESET     8'h00
`define SEHP_ADDR_BITS    13
`define SEHP_CLK_NS       100
`define SEHP_TWC_NS       5000000
`define SEHP_TWC_CYC      (`SEHP_TWC_NS / `SEHP_CLK_NS)
`endif

// [rtl/sehp_sync.v]
// two flip-flop synchroniser for one pin input
`timescale 1ns/1ns
`default_nettype none
module sehp_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire d_in,
  output reg  q_out
);
  reg meta_q;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RESET_VAL;
      q_out  <= RESET_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // sehp_sync
`default_nettype wire

// [rtl/sehp_wtimer.v]
// self-timed write cycle counter
`timescale 1ns/1ns
`default_nettype none
module sehp_wtimer #(
  parameter CYCLES = 50000
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire start_in,
  output wire busy_out
);
  reg [31:0] cnt_q;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 32'h0000_0000;
    end else if (start_in && cnt_q == 32'h0000_0000) begin
      cnt_q <= CYCLES;
    end else if (cnt_q != 32'h0000_0000) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end
  assign busy_out = (cnt_q != 32'h0000_0000);
endmodule // sehp_wtimer
`default_nettype wire

// [rtl/sehp_top.v]
// serial eeprom command logic: status write protect, reads, hold, write cycle
// Behaviour
// - status write changes only bits 2, 3 and 7
// - protect pin low with pin-enable set refuses status writes
// - protect pin falling while selected aborts pending status write
// - started status write cycle ignores the protect pin
// - pin-enable clear makes the protect pin irrelevant
// - after address, bytes shift out with pointer incrementing each byte
// - pointer wraps from top address to zero, endless read
// - chip select high ends the read and output shifting
// - after read status opcode, eight status bits shift out
// - read status answered any time, even during write cycle
// - while held: output high impedance, input ignored, position kept
// - reset leaves writes disabled and idle; enable needed before writes
// - successful array or status write clears the enable latch
// - write cycle starts at chip select rising after exact clocks
// - array commands ignored during internal write cycle
// - unknown opcode ignores rest of selection, output stays off
// - six eight-bit opcodes as defined
// - busy in status bit 0, enable latch in bit 1
// - only low thirteen address bits used
// - sample on rising serial clock, change output on falling
`include "sehp_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module sehp_top #(
  parameter WRITE_CYCLES = `SEHP_TWC_CYC,
  parameter ADDR_BITS    = `SEHP_ADDR_BITS
) (
  input  wire CLK_IN,
  input  wire RST_N_IN,
  input  wire CS_N_IN,
  input  wire SCK_IN,
  input  wire SI_IN,
  input  wire HOLD_N_IN,
  input  wire WP_N_IN,
  output reg  SO_OUT,
  output reg  SO_OE_OUT,
  output wire [7:0] STATUS_OUT,
  output reg  MEM_WE_OUT,
  output reg  [ADDR_BITS-1:0] MEM_ADDR_OUT,
  output reg  [7:0] MEM_WDATA_OUT,
  input  wire [7:0] MEM_RDATA_IN
);
  localparam S_CMD  = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_RDAT = 3'd2;
  localparam S_RST  = 3'd3;
  localparam S_WST  = 3'd4;
  localparam S_WDAT = 3'd5;
  localparam S_IGN  = 3'd6;

  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire hold_n_s;
  wire wp_n_s;
  sehp_sync #(.RESET_VAL(1'b0)) u_cs (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (~CS_N_IN),
    .q_out    (cs_n_s)
  );
  sehp_sync #(.RESET_VAL(1'b0)) u_sck (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (SCK_IN),
    .q_out    (sck_s)
  );
  sehp_sync #(.RESET_VAL(1'b0)) u_si (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (SI_IN),
    .q_out    (si_s)
  );
  sehp_sync #(.RESET_VAL(1'b0)) u_hold (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (~HOLD_N_IN),
    .q_out    (hold_n_s)
  );
  sehp_sync #(.RESET_VAL(1'b0)) u_wp (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (~WP_N_IN),
    .q_out    (wp_n_s)
  );
  // the synchronisers reset low, so selects are carried inverted
  wire sel      = cs_n_s;
  wire held     = hold_n_s;
  wire wp_low   = wp_n_s;

  reg        sck_q;
  reg        sel_q;
  reg        wp_low_q;
  reg [2:0]  state_q;
  reg [2:0]  bit_q;
  reg [3:0]  abit_q;
  reg [7:0]  sh_q;
  reg [15:0] addr_q;
  reg [7:0]  out_q;
  reg        is_read_q;
  reg        wel_q;
  reg        bpl_q;
  reg        bph_q;
  reg        ppen_q;
  reg [7:0]  wst_q;
  reg        wst_ok_q;
  reg        wr_ok_q;
  reg        wstart_q;

  wire busy;
  // write cycle length is a parameter so simulation can shorten it
  sehp_wtimer #(.CYCLES(WRITE_CYCLES)) u_tmr (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .start_in (wstart_q),
    .busy_out (busy)
  );

  wire [7:0] status = {ppen_q, 3'b000, bph_q, bpl_q, wel_q, busy};
  assign STATUS_OUT = status;

  // both edges only count while selected and not paused
  wire rise = sel && !held && sck_s && !sck_q;
  wire fall = sel && !held && !sck_s && sck_q;
  wire [7:0] byte_in = {sh_q[6:0], si_s};
  // protection is checked at the opcode, at the data end and again at the select edge
  wire sst_prot = ppen_q && wp_low;

  // pointer is exactly as wide as the array, so overflow wraps by itself
  function [ADDR_BITS-1:0] next_addr;
    input [ADDR_BITS-1:0] a;
    begin
      next_addr = a + 1'b1;  // natural wrap to zero
    end
  endfunction

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sck_q        <= 1'b0;
      sel_q        <= 1'b0;
      wp_low_q     <= 1'b0;
      state_q      <= S_CMD;
      bit_q        <= 3'd0;
      abit_q       <= 4'd0;
      sh_q         <= 8'h00;
      addr_q       <= 16'h0000;
      out_q        <= 8'h00;
      is_read_q    <= 1'b0;
      wel_q        <= 1'b0;
      bpl_q        <= 1'b0;
      bph_q        <= 1'b0;
      ppen_q       <= 1'b0;
      wst_q        <= `SEHP_ST_RESET;
      wst_ok_q     <= 1'b0;
      wr_ok_q      <= 1'b0;
      wstart_q     <= 1'b0;
      SO_OUT       <= 1'b0;
      SO_OE_OUT    <= 1'b0;
      MEM_WE_OUT   <= 1'b0;
      MEM_ADDR_OUT <= {ADDR_BITS{1'b0}};
      MEM_WDATA_OUT <= 8'h00;
    end else begin
      // sck is tracked even while held, so release gives no false edge
      sck_q      <= sck_s;
      sel_q      <= sel;
      wp_low_q   <= wp_low;
      wstart_q   <= 1'b0;
      MEM_WE_OUT <= 1'b0;
      if (!sel) begin
        // deselect ends any sequence and silences the output
        state_q   <= S_CMD;
        bit_q     <= 3'd0;
        SO_OE_OUT <= 1'b0;
        if (sel_q) begin
          // bits land at the select edge, so a later protect pin fall cannot reach them
          if (wst_ok_q && !sst_prot) begin
            bpl_q    <= wst_q[`SEHP_ST_BPL];
            bph_q    <= wst_q[`SEHP_ST_BPH];
            ppen_q   <= wst_q[`SEHP_ST_PPEN];
            wel_q    <= 1'b0;
            wstart_q <= 1'b1;
          end else if (wr_ok_q) begin
            MEM_WE_OUT <= 1'b1;
            wel_q      <= 1'b0;
            wstart_q   <= 1'b1;
          end
        end
        wst_ok_q <= 1'b0;
        wr_ok_q  <= 1'b0;
      end else begin
        // enable is registered so it never glitches on a select change
        if (held) begin
          SO_OE_OUT <= 1'b0;
        end else if (state_q == S_RDAT || state_q == S_RST) begin
          SO_OE_OUT <= 1'b1;
        end
        // protect pin falling mid-selection cancels the pending status write
        if (wp_low && !wp_low_q && ppen_q) begin
          wst_ok_q <= 1'b0;
          if (state_q == S_WST) begin
            state_q <= S_IGN;  // a pulse mid-byte must not be forgotten
          end
        end
        if (rise) begin
          sh_q  <= byte_in;  // msb first
          bit_q <= bit_q + 3'd1;
          case (state_q)
            // status read is decoded before busy so it is always answered
            S_CMD: begin
              if (bit_q == 3'd7) begin
                sh_q <= 8'h00;
                if (byte_in == `SEHP_OP_RDST) begin
                  state_q <= S_RST;
                  out_q   <= status;
                end else if (busy) begin
                  state_q <= S_IGN;
                end else if (byte_in == `SEHP_OP_WRITE_ENABLE_COMMAND) begin
                  wel_q   <= 1'b1;
                  state_q <= S_IGN;
                end else if (byte_in == `SEHP_OP_WRITE_DISABLE_COMMAND) begin
                  wel_q   <= 1'b0;
                  state_q <= S_IGN;
                end else if (byte_in == `SEHP_OP_WRST) begin
                  state_q <= (wel_q && !sst_prot) ? S_WST : S_IGN;
                end else if (byte_in == `SEHP_OP_READ) begin
                  is_read_q <= 1'b1;
                  abit_q    <= 4'd0;
                  state_q   <= S_ADDR;
                end else if (byte_in == `SEHP_OP_WRITE) begin
                  is_read_q <= 1'b0;
                  abit_q    <= 4'd0;
                  state_q   <= wel_q ? S_ADDR : S_IGN;
                end else begin
                  state_q <= S_IGN;
                end
              end
            end
            // upper three address bits shift through but never reach the array
            S_ADDR: begin
              addr_q <= {addr_q[14:0], si_s};
              abit_q <= abit_q + 4'd1;
              bit_q  <= 3'd0;
              if (abit_q == 4'd15) begin
                MEM_ADDR_OUT <= {addr_q[ADDR_BITS-2:0], si_s};
                state_q      <= is_read_q ? S_RDAT : S_WDAT;
              end
            end
            S_WST: begin
              if (bit_q == 3'd7) begin
                wst_q    <= byte_in & `SEHP_ST_WR_MASK;
                wst_ok_q <= !sst_prot;
                state_q  <= S_IGN;  // extra clocks void the write
              end
            end
            S_WDAT: begin
              // array loading itself lives outside; only one byte latched here
              wr_ok_q <= (bit_q == 3'd7);
              if (bit_q == 3'd7) begin
                MEM_WDATA_OUT <= byte_in;
              end
            end
            S_IGN: begin
              wst_ok_q <= 1'b0;
            end
            default: begin
            end
          endcase
        end
        // array data is combinational, so each byte is taken at the fall that shows its msb
        if (fall) begin
          if (state_q == S_RDAT) begin
            if (bit_q == 3'd0) begin
              SO_OUT <= MEM_RDATA_IN[7];
              out_q  <= {MEM_RDATA_IN[6:0], 1'b0};
              MEM_ADDR_OUT <= next_addr(MEM_ADDR_OUT);
            end else begin
              SO_OUT <= out_q[7];
              out_q  <= {out_q[6:0], 1'b0};
            end
          end else if (state_q == S_RST) begin
            if (bit_q == 3'd0) begin
              SO_OUT <= status[7];
              out_q  <= {status[6:0], 1'b0};
            end else begin
              SO_OUT <= out_q[7];
              out_q  <= {out_q[6:0], 1'b0};
            end
          end
        end
      end
    end
  end
endmodule // sehp_top
`default_nettype wire

// [test/sehp_top_props.sv]
// pin-level assertions for the eeprom command block
`timescale 1ns/1ns
`default_nettype none
module sehp_top_props #(
  parameter WRITE_CYCLES = 20,
  parameter ADDR_BITS    = 13
) (
  input wire logic                 CLK_IN,
  input wire logic                 RST_N_IN,
  input wire logic                 CS_N_IN,
  input wire logic                 HOLD_N_IN,
  input wire logic                 WP_N_IN,
  input wire logic                 SO_OE_OUT,
  input wire logic [7:0]           STATUS_OUT,
  input wire logic                 MEM_WE_OUT,
  input wire logic [ADDR_BITS-1:0] MEM_ADDR_OUT
);
  logic [15:0] busy_cnt_q;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // five cycles covers the pin synchroniser plus the output register
  sequence s_deselected; CS_N_IN [*5]; endsequence
  sequence s_held; !HOLD_N_IN [*5]; endsequence
  sequence s_write_start; $rose(STATUS_OUT[0]); endsequence
  always @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN) busy_cnt_q <= 16'h0000;
    else busy_cnt_q <= STATUS_OUT[0] ? busy_cnt_q + 16'h0001 : 16'h0000;
  a_desel_out_off: assert property (s_deselected |-> !SO_OE_OUT)
    else $error("output enabled while deselected");
  a_hold_out_off: assert property (s_held |-> !SO_OE_OUT)
    else $error("output enabled while held");
  a_status_zero_bits: assert property (STATUS_OUT[6:4] == 3'h0)
    else $error("unused status bits not zero");
  a_status_on_write: assert property ($changed(STATUS_OUT[7:2]) |-> ##[0:1] STATUS_OUT[0])
    else $error("status bits changed outside a write");
  a_pin_refuses: assert property ($changed(STATUS_OUT[7:2]) |->
    !$past(STATUS_OUT[7]) || $past(WP_N_IN, 3)) else $error("protected status written");
  a_write_clears_wel: assert property (s_write_start |-> !STATUS_OUT[1])
    else $error("enable latch kept after write start");
  a_write_after_cs: assert property (s_write_start |-> CS_N_IN && $past(CS_N_IN, 2))
    else $error("write cycle started while selected");
  a_mem_we_pulse: assert property (MEM_WE_OUT |-> CS_N_IN ##1 !MEM_WE_OUT)
    else $error("array write strobe malformed");
  a_busy_bounded: assert property (busy_cnt_q <= WRITE_CYCLES + 2)
    else $error("busy too long");
  a_busy_full: assert property ($fell(STATUS_OUT[0]) |-> $past(busy_cnt_q) >= WRITE_CYCLES - 2)
    else $error("busy too short");
  a_ptr_selected: assert property ($changed(MEM_ADDR_OUT) |->
    !$past(CS_N_IN, 3) && $past(HOLD_N_IN, 3)) else $error("array pointer moved while idle or held");
endmodule // sehp_top_props
`default_nettype wire

// [test/sehp_host.sv]
// host serial controller model, clock modes 0 and 3
`timescale 1ns/1ns
`default_nettype none
module sehp_host (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic so_oe,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si,
  output var  logic hold_n,
  output var  logic wp_n
);
  logic oe_seen, idle_hi;
  initial begin
    {cs_n, sck, si, hold_n, wp_n, oe_seen} = 6'b100110;
    idle_hi = 1'b0;
  end
  always @(posedge clk) if (so_oe) oe_seen <= 1'b1;
  task automatic wt(input int n); repeat (n) @(negedge clk); endtask
  task automatic start(); wt(1); oe_seen = 0; cs_n = 0; wt(4); endtask
  // data set while sck low, read back mid high phase when settled
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 0; si = tx[i]; wt(4);
      // a released line reads as the inverse of its last value
      sck = 1; wt(2); rx[i] = so_oe ? so : ~so; wt(2);
    end
  endtask
  // sck parks at its idle level outside frames; si shows no stale value
  task automatic stop(); sck = idle_hi; wt(4); cs_n = 1; si = ~si; wt(8); endtask
  task automatic pause(output logic oe);
    sck = 0; wt(4); hold_n = 0; wt(8);
    repeat (4) begin si = ~si; wt(2); end
    oe = so_oe; hold_n = 1; wt(4);
  endtask
endmodule // sehp_host
`default_nettype wire

// [test/sehp_top_tb.sv]
// self-checking bench for the eeprom command block
`timescale 1ns/1ns
`default_nettype none
module sehp_top_tb;
  localparam int WC = 300;
  logic clk, rst_n, oe_h;
  logic [7:0] r;
  int mismatches = 0, checks_done = 0, cyc = 0;
  wire logic cs_n, sck, si, hold_n, wp_n, so, oe, we;
  wire logic [7:0] st, wd, rd;
  wire logic [12:0] ad;
  function automatic logic [7:0] mem(input logic [12:0] a); return a[7:0] ^ {3'h0, a[12:8]}; endfunction
  assign rd = mem(ad);
  sehp_host host (.clk(clk), .so(so), .so_oe(oe), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n));
  sehp_top #(.WRITE_CYCLES(WC)) DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(cs_n),
    .SCK_IN(sck), .SI_IN(si), .HOLD_N_IN(hold_n), .WP_N_IN(wp_n), .SO_OUT(so),
    .SO_OE_OUT(oe), .STATUS_OUT(st), .MEM_WE_OUT(we), .MEM_ADDR_OUT(ad),
    .MEM_WDATA_OUT(wd), .MEM_RDATA_IN(rd));
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op); host.start(); host.xbyte(op, r); host.stop(); endtask
  task automatic wrst(input logic [7:0] d);
    cmd(8'h06); host.start(); host.xbyte(8'h01, r); host.xbyte(d, r); host.stop();
  endtask
  task automatic rdst(input logic [7:0] exp);
    host.start(); host.xbyte(8'h05, r); host.xbyte(8'h00, r); host.stop(); chk(r, exp);
  endtask
  task automatic idle(); for (int i = 0; i < 2 * WC && st[0] === 1'b1; i++) @(negedge clk); endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    rst_n = 0;
    repeat (20) @(negedge clk);
    rst_n = 1;
    host.wt(4);
    chk(st, 8'h00);
    rdst(8'h00);
    host.start(); host.xbyte(8'h01, r); host.xbyte(8'hFF, r); host.stop();
    chk(st, 8'h00);
    cmd(8'h06); chk(st, 8'h02);
    cmd(8'h04); chk(st, 8'h00);
    wrst(8'hFF); chk(st, 8'h8D);
    rdst(8'h8D);
    cmd(8'h06); chk(st, 8'h8D);
    idle(); chk(st, 8'h8C);
    host.wp_n = 0; wrst(8'h00); chk(st & 8'hFD, 8'h8C);
    host.wp_n = 1; cmd(8'h06); host.start(); host.xbyte(8'h01, r); host.xbyte(8'h00, r);
    host.wp_n = 0; host.wt(4); host.wp_n = 1; host.stop(); chk(st & 8'hFD, 8'h8C);
    wrst(8'h00); host.wp_n = 0; idle(); chk(st, 8'h00);
    wrst(8'h0C); chk(st, 8'h0D); idle(); host.wp_n = 1;
    cmd(8'h06); host.start(); host.xbyte(8'h02, r); host.xbyte(8'h00, r);
    host.xbyte(8'h10, r); host.xbyte(8'hA5, r); host.stop();
    chk(wd, 8'hA5); chk(st, 8'h0D); idle();
    host.start(); host.xbyte(8'h03, r); host.xbyte(8'hFF, r); host.xbyte(8'hFE, r);
    host.xbyte(8'h00, r); chk(r, mem(13'h1FFE));
    host.pause(oe_h); chk({7'h00, oe_h}, 8'h00);
    host.xbyte(8'h00, r); chk(r, mem(13'h1FFF));
    host.xbyte(8'h00, r); chk(r, mem(13'h0000));
    host.stop(); chk({7'h00, oe}, 8'h00);
    host.start(); host.xbyte(8'hFF, r); host.xbyte(8'h00, r); host.stop();
    chk({7'h00, host.oe_seen}, 8'h00);
    host.idle_hi = 1; host.sck = 1; rdst(8'h0C);
    cmd(8'h06); rst_n = 0; host.wt(2); rst_n = 1; host.wt(4); chk(st, 8'h00);
    complete_run();
  end
endmodule // sehp_top_tb
bind sehp_top sehp_top_props #(.WRITE_CYCLES(WRITE_CYCLES), .ADDR_BITS(ADDR_BITS)) u_props (.*);
`default_nettype wire
